/* design/cmc_bus_gate.sv */
// tx pin gating and monitor path toward the protocol engine.
// assumes bus_rx_pin is asynchronous; other inputs are on clk.
module cmc_bus_gate (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic bus_rx_pin,
  input  wire logic mac_tx_bit,
  input  wire logic listen_only,
  input  wire logic force_recessive,
  output logic      bus_tx_pin,
  output logic      mac_rx_bit
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rx_meta; // first synchroniser stage
    logic rx_sync; // second synchroniser stage
    logic tx_pin;  // driven bus level
    logic mon;     // bit seen by the protocol monitor
  } cmc_gate_s;

  cmc_gate_s s;      // registered state
  cmc_gate_s next_s; // next state

  // gating and loop-back
  always_comb
  begin
    next_s         = s;
    next_s.rx_meta = bus_rx_pin;
    next_s.rx_sync = s.rx_meta;
    // init, sleep, off and listen-only all keep the wire recessive
    if (force_recessive || listen_only)
      next_s.tx_pin = cmc_pkg::RECESSIVE;
    else
      next_s.tx_pin = mac_tx_bit;
    // in listen-only, a dominant bit the engine wants is looped back internally
    if (listen_only)
      next_s.mon = s.rx_sync & mac_tx_bit;
    else
      next_s.mon = s.rx_sync;
  end

  // registers, frozen while ce is low
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s.rx_meta <= cmc_pkg::RECESSIVE;
      s.rx_sync <= cmc_pkg::RECESSIVE;
      s.tx_pin  <= cmc_pkg::RECESSIVE;
      s.mon     <= cmc_pkg::RECESSIVE;
    end
    else if (ce)
      s <= next_s;
  end

  assign bus_tx_pin = s.tx_pin;
  assign mac_rx_bit = s.mon;

endmodule

/* design/cmc_mode_fsm.sv */
// mode sequencer: off, initialization, run and sleep.
// assumes requests come from flip-flops on the same clock.
module cmc_mode_fsm (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  cmc_mode_if.fsm  mif
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    cmc_pkg::cmc_state_e state; // current mode
  } cmc_fsm_s;

  cmc_fsm_s s;      // registered state
  cmc_fsm_s next_s; // next state

  // next mode; leaving run for sleep waits for the engine to go idle
  always_comb
  begin
    next_s = s;
    case (s.state)
      cmc_pkg::ST_OFF:
      begin
        if (mif.module_enable)
          next_s.state = cmc_pkg::ST_INIT;
      end
      cmc_pkg::ST_INIT:
      begin
        if (!mif.module_enable)
          next_s.state = cmc_pkg::ST_OFF;
        else if (!mif.init_request)
          next_s.state = cmc_pkg::ST_RUN;
      end
      cmc_pkg::ST_RUN:
      begin
        if (!mif.module_enable)
          next_s.state = cmc_pkg::ST_OFF;
        else if (mif.init_request)
          next_s.state = cmc_pkg::ST_INIT;
        else if (mif.sleep_request && !mif.mac_busy)
          next_s.state = cmc_pkg::ST_SLEEP;
      end
      cmc_pkg::ST_SLEEP:
      begin
        if (!mif.module_enable)
          next_s.state = cmc_pkg::ST_OFF;
        else if (mif.init_request)
          next_s.state = cmc_pkg::ST_INIT;
        else if (!mif.sleep_request)
          next_s.state = cmc_pkg::ST_RUN;
      end
      default:
        next_s.state = cmc_pkg::ST_OFF;
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk)
  begin
    if (srst)
      s.state <= cmc_pkg::ST_OFF;
    else if (ce)
      s <= next_s;
  end

  assign mif.in_init    = (s.state == cmc_pkg::ST_INIT);
  assign mif.in_sleep   = (s.state == cmc_pkg::ST_SLEEP);
  assign mif.running    = (s.state == cmc_pkg::ST_RUN);
  // one-cycle look-ahead so the register file resets on the same edge
  assign mif.enter_init = ce && (s.state != cmc_pkg::ST_INIT)
                          && (next_s.state == cmc_pkg::ST_INIT);

endmodule

/* design/cmc_mode_if.sv */
// interface carrying mode requests to the mode sequencer and its answers.
// assumes both ends run on the same clock.
interface cmc_mode_if;
  logic module_enable; // software enable
  logic init_request;  // software asks for initialization
  logic sleep_request; // software asks for sleep
  logic mac_busy;      // protocol engine is inside a frame
  logic in_init;       // sequencer sits in initialization
  logic in_sleep;      // sequencer sits in sleep
  logic running;       // protocol engine may run
  logic enter_init;    // initialization is entered at the coming edge

  modport fsm (input module_enable, init_request, sleep_request, mac_busy,
               output in_init, in_sleep, running, enter_init);
  modport ctl (output module_enable, init_request, sleep_request, mac_busy,
               input in_init, in_sleep, running, enter_init);
endinterface

/* design/cmc_pkg.sv */
// package for the can mode-control block: register map, field positions,
// reset values, mode and state encodings.
// assumes one 50 MHz clock and an 8-bit register port of 6 address bits.
package cmc_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses on the register port)
  // ---------------------------------------------------------------
  localparam logic [5:0] ADR_CTL0  = 6'h00; // control_reg_0
  localparam logic [5:0] ADR_CTL1  = 6'h01; // enable, listen-only, status
  localparam logic [5:0] ADR_BTR0  = 6'h02; // bit_timing_reg_0
  localparam logic [5:0] ADR_BTR1  = 6'h03; // bit_timing_reg_1
  localparam logic [5:0] ADR_RFLG  = 6'h04; // receiver_flag_reg
  localparam logic [5:0] ADR_RIER  = 6'h05; // receiver_irq_enable_reg
  localparam logic [5:0] ADR_TFLG  = 6'h06; // transmit_flag_reg
  localparam logic [5:0] ADR_TIER  = 6'h07; // transmit_irq_enable_reg
  localparam logic [5:0] ADR_TARQ  = 6'h08; // abort_request_reg
  localparam logic [5:0] ADR_TAAK  = 6'h09; // abort_ack_reg
  localparam logic [5:0] ADR_TBSEL = 6'h0A; // tx_buffer_select_reg
  localparam logic [5:0] ADR_IDAC  = 6'h0B; // acceptance_control_reg
  localparam logic [5:0] ADR_IDAR  = 6'h10; // acceptance_code_regs, 4 bytes
  localparam logic [5:0] ADR_IDMR  = 6'h14; // acceptance_mask_regs, 4 bytes

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL0_INIT    = 0; // init_request
  localparam int CTL0_SLEEP   = 1; // sleep_request
  localparam int CTL1_INITACK = 0; // read-only: in initialization mode
  localparam int CTL1_SLPACK  = 1; // read-only: sleep_acknowledge
  localparam int CTL1_LISTEN  = 4; // listen-only monitoring
  localparam int CTL1_ENABLE  = 7; // module_enable
  localparam int RFLG_RXF     = 0; // receive buffer holds a frame
  localparam int FILT_N       = 4; // bytes per filter bank

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTL0 = 8'h01; // init_request set
  localparam logic [7:0] RST_TFLG = 8'h07; // three tx buffers empty
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic       RECESSIVE = 1'b1;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_INIT  = 2'b01,
    ST_RUN   = 2'b10,
    ST_SLEEP = 2'b11
  } cmc_state_e;

  typedef enum logic [1:0] {
    SYS_NORMAL  = 2'b00,
    SYS_SPECIAL = 2'b01,
    SYS_EMUL    = 2'b10
  } cmc_sysmode_e;

endpackage

/* design/cmc_top.sv */
// can controller mode control: register file, mode sequencing, pin gating.
// assumes a protocol engine on the same clock drives the mac_* inputs and
// obeys engine_run, engine_abort and mac_tx_grant.
// the register port never waits.
//
// Overview of operation
// - special modes lift configuration write locks
// - emulation modes behave exactly like normal
// - listen-only still receives and stores frames
// - listen-only: recessive only, no transmission start
// - listen-only dominant bits loop back internally
// - enabling the module enters initialization first
// - entering initialization aborts frames, drops sync
// - entering initialization forces tx pin recessive
// - initialization halts engine, registers stay accessible
// - initialization resets control_reg_0, flag, select registers
// - initialization allows timing and filter writes
module cmc_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // register port
  input  wire logic [5:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // system operating mode
  input  wire logic [1:0]  sys_mode,
  // protocol engine side
  input  wire logic        mac_tx_bit,
  input  wire logic        mac_busy,
  input  wire logic        mac_tx_request,
  input  wire logic        mac_rx_frame_ok,
  output logic             mac_tx_grant,
  output logic             mac_rx_bit,
  output logic             engine_run,
  output logic             engine_abort,
  // configuration copies
  output logic      [7:0]  cfg_timing_0,
  output logic      [7:0]  cfg_timing_1,
  output logic      [7:0]  cfg_accept_ctl,
  output logic      [31:0] cfg_accept_code,
  output logic      [31:0] cfg_accept_mask,
  // can bus pins
  input  wire logic        bus_rx_pin,
  output logic             bus_tx_pin
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            ctl0;   // control_reg_0
    logic                  enable; // module_enable
    logic                  listen; // listen-only select
    logic [7:0]            btr0;   // bit_timing_reg_0
    logic [7:0]            btr1;   // bit_timing_reg_1
    logic [7:0]            rflg;   // receiver_flag_reg
    logic [7:0]            rier;   // receiver_irq_enable_reg
    logic [7:0]            tflg;   // transmit_flag_reg
    logic [7:0]            tier;   // transmit_irq_enable_reg
    logic [7:0]            tarq;   // abort_request_reg
    logic [7:0]            taak;   // abort_ack_reg
    logic [7:0]            tbsel;  // tx_buffer_select_reg
    logic [7:0]            idac;   // acceptance_control_reg
    logic [3:0][7:0]       idar;   // acceptance_code_regs
    logic [3:0][7:0]       idmr;   // acceptance_mask_regs
    logic [7:0]            rdata;  // read answer, valid one cycle
    logic                  abort;  // abort pulse to the engine
  } cmc_top_s;

  cmc_top_s s;      // registered state
  cmc_top_s next_s; // next state
  // one struct: one ce, one srst

  cmc_mode_if mif (); // link to the mode sequencer

  // decoded helpers
  logic cfg_open;    // configuration registers may be written
  logic special;     // special system mode
  logic [7:0] ctl1_rd; // assembled status view
  logic force_rec;   // keep the bus wire recessive
  logic [7:0] wr_sel;  // one-hot decode of the registers at 0x00 to 0x07

  // ---------------------------------------------------------------
  // mode sequencer and pin gate
  // ---------------------------------------------------------------
  // requests come from flops
  assign mif.module_enable = s.enable;
  assign mif.init_request  = s.ctl0[cmc_pkg::CTL0_INIT];
  assign mif.sleep_request = s.ctl0[cmc_pkg::CTL0_SLEEP];
  assign mif.mac_busy      = mac_busy;

  // off, init, run and sleep
  cmc_mode_fsm u_fsm (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .mif  (mif)
  );

  // a pending init request already forces recessive, so the pin goes
  // quiet on the same edge the sequencer enters initialization
  assign force_rec = !mif.running || mif.init_request;

  cmc_bus_gate u_gate (
    .clk             (clk),
    .srst            (srst),
    .ce              (ce),
    .bus_rx_pin      (bus_rx_pin),
    .mac_tx_bit      (mac_tx_bit),
    .listen_only     (s.listen),
    .force_recessive (force_rec),
    .bus_tx_pin      (bus_tx_pin),
    .mac_rx_bit      (mac_rx_bit)
  );

  // ---------------------------------------------------------------
  // write permissions
  // ---------------------------------------------------------------
  // emulation and undefined codes fall through to normal behaviour
  assign special  = (sys_mode == cmc_pkg::SYS_SPECIAL);

  // timing and filters only change in initialization or under special modes
  assign cfg_open = mif.in_init || special;

  // status view of the second control register
  // ack bits mirror the sequencer
  always_comb
  begin
    // other bits read zero
    ctl1_rd                        = cmc_pkg::RST_ZERO;
    ctl1_rd[cmc_pkg::CTL1_ENABLE]  = s.enable;
    ctl1_rd[cmc_pkg::CTL1_LISTEN]  = s.listen;
    ctl1_rd[cmc_pkg::CTL1_SLPACK]  = mif.in_sleep;
    ctl1_rd[cmc_pkg::CTL1_INITACK] = mif.in_init;
  end

  // one-hot write decode for the addresses 0x00 to 0x07
  // higher ones compare in full
  always_comb
  begin
    wr_sel = 8'h00;
    if (wr && (addr[5:3] == 3'h0))
      wr_sel[addr[2:0]] = 1'b1;
  end

  // ---------------------------------------------------------------
  // register file and side effects
  // ---------------------------------------------------------------
  // registers stay readable in every mode and writable except abort_ack_reg outside special modes; only the
  // configuration group and the listen-only bit are gated by cfg_open
  always_comb
  begin
    next_s       = s;
    next_s.rdata = cmc_pkg::RST_ZERO;
    next_s.abort = mif.enter_init;
    // writes first; hardware events below win, except that a special-mode abort_ack_reg write beats the acknowledge copy

    // control_reg_0: init and sleep requests and spare bits
    if (wr_sel[cmc_pkg::ADR_CTL0[2:0]])
      next_s.ctl0 = wdata;

    // enable and listen-only; listen-only is a setting, so lock it too
    if (wr_sel[cmc_pkg::ADR_CTL1[2:0]])
    begin
      // enable never locks
      next_s.enable = wdata[cmc_pkg::CTL1_ENABLE];
      if (cfg_open)
        next_s.listen = wdata[cmc_pkg::CTL1_LISTEN];
    end

    // a disabled module waits with its init request raised
    if (!s.enable)
      next_s.ctl0[cmc_pkg::CTL0_INIT] = 1'b1;

    // bit timing, written only while configuration is open
    if (wr_sel[cmc_pkg::ADR_BTR0[2:0]] && cfg_open)
      next_s.btr0 = wdata;
    if (wr_sel[cmc_pkg::ADR_BTR1[2:0]] && cfg_open)
      next_s.btr1 = wdata;

    // receiver flags: write one to clear
    if (wr_sel[cmc_pkg::ADR_RFLG[2:0]])
      next_s.rflg = s.rflg & ~wdata;

    // a frame arriving in the clearing cycle still sets its flag;
    // listen-only keeps receiving
    if (mac_rx_frame_ok && mif.running)
      next_s.rflg[cmc_pkg::RFLG_RXF] = 1'b1;

    // enables are plain storage
    if (wr_sel[cmc_pkg::ADR_RIER[2:0]])
      next_s.rier = wdata;

    // a one claims a buffer
    if (wr_sel[cmc_pkg::ADR_TFLG[2:0]])
      next_s.tflg = s.tflg & ~wdata; // software marks buffers full

    if (wr_sel[cmc_pkg::ADR_TIER[2:0]])
      next_s.tier = wdata;

    // abort request and acknowledge
    if (wr && (addr == cmc_pkg::ADR_TARQ))
      next_s.tarq = wdata;

    // the engine acknowledges once no frame is in flight
    if (!mac_busy)
      next_s.taak = s.tarq;

    // the acknowledge is read-only except under special modes
    if (wr && (addr == cmc_pkg::ADR_TAAK) && special)
      next_s.taak = wdata;

    // buffer select
    if (wr && (addr == cmc_pkg::ADR_TBSEL))
      next_s.tbsel = wdata;

    // acceptance control and filter banks
    if (wr && (addr == cmc_pkg::ADR_IDAC) && cfg_open)
      next_s.idac = wdata;

    // one compare per byte
    for (int i = 0; i < cmc_pkg::FILT_N; i++)
    begin
      // code byte
      if (wr && cfg_open && (addr == cmc_pkg::ADR_IDAR + 6'(i)))
        next_s.idar[i] = wdata;
      // mask byte
      if (wr && cfg_open && (addr == cmc_pkg::ADR_IDMR + 6'(i)))
        next_s.idmr[i] = wdata;
    end

    // entering initialization overrides any write in the same cycle
    // timing, filters, enable and listen-only survive it
    if (mif.enter_init)
    begin
      next_s.ctl0  = cmc_pkg::RST_CTL0;
      next_s.rflg  = cmc_pkg::RST_ZERO;
      next_s.rier  = cmc_pkg::RST_ZERO;
      next_s.tflg  = cmc_pkg::RST_TFLG;
      next_s.tier  = cmc_pkg::RST_ZERO;
      next_s.tarq  = cmc_pkg::RST_ZERO;
      next_s.taak  = cmc_pkg::RST_ZERO;
      next_s.tbsel = cmc_pkg::RST_ZERO;
    end

    // read decode; unmapped addresses answer zero
    // reads see pre-write values
    if (rd)
    begin
      // small registers by address
      case (addr)
        cmc_pkg::ADR_CTL0:  next_s.rdata = s.ctl0;
        cmc_pkg::ADR_CTL1:  next_s.rdata = ctl1_rd;
        cmc_pkg::ADR_BTR0:  next_s.rdata = s.btr0;
        cmc_pkg::ADR_BTR1:  next_s.rdata = s.btr1;
        cmc_pkg::ADR_RFLG:  next_s.rdata = s.rflg;
        cmc_pkg::ADR_RIER:  next_s.rdata = s.rier;
        cmc_pkg::ADR_TFLG:  next_s.rdata = s.tflg;
        cmc_pkg::ADR_TIER:  next_s.rdata = s.tier;
        cmc_pkg::ADR_TARQ:  next_s.rdata = s.tarq;
        cmc_pkg::ADR_TAAK:  next_s.rdata = s.taak;
        cmc_pkg::ADR_TBSEL: next_s.rdata = s.tbsel;
        cmc_pkg::ADR_IDAC:  next_s.rdata = s.idac;
        default:
        begin
          // filter banks sit in two aligned groups of four
          if (addr[5:3] == cmc_pkg::ADR_IDAR[5:3])
            next_s.rdata = addr[2] ? s.idmr[addr[1:0]] : s.idar[addr[1:0]];
          else
            next_s.rdata = cmc_pkg::RST_ZERO;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // all state frozen while ce is low; the read answer too, so a read
  // strobe must be given in a cycle with ce high
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // control
      s.ctl0   <= cmc_pkg::RST_CTL0;
      s.enable <= 1'b0;
      s.listen <= 1'b0;
      // bit timing
      s.btr0   <= cmc_pkg::RST_ZERO;
      s.btr1   <= cmc_pkg::RST_ZERO;
      // flags and buffers
      s.rflg   <= cmc_pkg::RST_ZERO;
      s.rier   <= cmc_pkg::RST_ZERO;
      s.tflg   <= cmc_pkg::RST_TFLG;
      s.tier   <= cmc_pkg::RST_ZERO;
      s.tarq   <= cmc_pkg::RST_ZERO;
      s.taak   <= cmc_pkg::RST_ZERO;
      s.tbsel  <= cmc_pkg::RST_ZERO;
      // filter
      s.idac   <= cmc_pkg::RST_ZERO;
      s.idar   <= '0;
      s.idmr   <= '0;
      // port and pulse
      s.rdata  <= cmc_pkg::RST_ZERO;
      s.abort  <= 1'b0;
    end
    else if (ce)
      s <= next_s;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // straight from the flop
  assign rdata           = s.rdata;
  // the engine only runs in run mode, so it is halted in init
  assign engine_run      = mif.running;

  // one clean cycle
  assign engine_abort    = s.abort;

  // a start needs run mode, no listen-only and an empty-flagged buffer
  // cleared by software; listen-only never starts a frame
  assign mac_tx_grant    = mac_tx_request
                           && mif.running
                           && !s.listen
                           && ((s.tflg[2:0] & s.tbsel[2:0]) != 3'h7)
                           && (s.tflg[2:0] != 3'h7);

  // configuration copies
  assign cfg_timing_0    = s.btr0;
  assign cfg_timing_1    = s.btr1;
  assign cfg_accept_ctl  = s.idac;
  // byte i at bits 8i+7:8i
  assign cfg_accept_code = s.idar;
  assign cfg_accept_mask = s.idmr;

endmodule

/* test/cmc_can_node.sv */
// other node on the can bus: wired-and of both transmitters.
// assumes node_dominant comes from the bench on the block's clock.
module cmc_can_node (
  input  wire logic node_dominant, // this node pulls the bus low
  input  wire logic bus_tx_pin,    // transmitter of the block
  output logic      bus_rx_pin     // resulting bus level
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------
  // bus level
  // --------------------------------------------
  // pull-up: a released bus reads recessive, dominant always wins
  assign bus_rx_pin = bus_tx_pin & ~node_dominant;
endmodule

/* test/cmc_top_chk.sv */
// checker for cmc_top: pin, mode and register-port relations.
// assumes a bind to cmc_top; sees only its ports.
module cmc_top_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [1:0] sys_mode,
  input wire logic       mac_tx_grant,
  input wire logic       engine_run,
  input wire logic       engine_abort,
  input wire logic [7:0] cfg_timing_0,
  input wire logic [7:0] cfg_timing_1,
  input wire logic       bus_tx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------
  // assertions
  // --------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_init_pin;
    ce && wr && addr == cmc_pkg::ADR_CTL0 && wdata[cmc_pkg::CTL0_INIT] |-> ##2 bus_tx_pin;
  endproperty
  a_init_pin: assert property (p_init_pin) else $error("tx pin not recessive after init request");
  property p_idle_pin;
    !engine_run |=> bus_tx_pin;
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("tx pin driven while engine halted");
  property p_grant;
    !engine_run |-> !mac_tx_grant;
  endproperty
  a_grant: assert property (p_grant) else $error("start granted while engine halted");
  property p_abort;
    engine_abort |-> !engine_run ##1 !engine_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  property p_rdata;
    ce && !rd |=> rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data without read");
  property p_enable;
    ce && wr && addr == cmc_pkg::ADR_CTL1 && wdata[cmc_pkg::CTL1_ENABLE] && !engine_run |=> !engine_run;
  endproperty
  a_enable: assert property (p_enable) else $error("enable went straight to run");
  property p_lock;
    ce && wr && addr == cmc_pkg::ADR_BTR0 && engine_run && sys_mode != cmc_pkg::SYS_SPECIAL
      |=> $stable(cfg_timing_0);
  endproperty
  a_lock: assert property (p_lock) else $error("timing written outside init");
  property p_special;
    ce && wr && addr == cmc_pkg::ADR_BTR1 && sys_mode == cmc_pkg::SYS_SPECIAL
      |=> cfg_timing_1 == $past(wdata);
  endproperty
  a_special: assert property (p_special) else $error("special mode write lost");
endmodule

bind cmc_top cmc_top_chk u_chk (.clk, .srst, .ce, .addr, .wdata, .wr, .rd, .rdata, .sys_mode,
  .mac_tx_grant, .engine_run, .engine_abort, .cfg_timing_0, .cfg_timing_1, .bus_tx_pin);

/* test/cmc_top_tb_top.sv */
// self-checking bench for cmc_top with one other bus node.
// assumes the checker is bound in; ce stays high throughout.
module cmc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, ce, wr, rd, mac_tx_bit, mac_busy, mac_tx_request, mac_rx_frame_ok;
  logic node_dominant, mac_tx_grant, mac_rx_bit, engine_run, engine_abort, bus_rx_pin, bus_tx_pin;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [1:0] sys_mode;
  logic [7:0] cfg_timing_0, cfg_timing_1, cfg_accept_ctl;
  logic [31:0] cfg_accept_code, cfg_accept_mask;
  int err_count, checked;

  cmc_top DUT (.clk, .srst, .ce, .addr, .wdata, .wr, .rd, .rdata, .sys_mode, .mac_tx_bit,
    .mac_busy, .mac_tx_request, .mac_rx_frame_ok, .mac_tx_grant, .mac_rx_bit, .engine_run,
    .engine_abort, .cfg_timing_0, .cfg_timing_1, .cfg_accept_ctl, .cfg_accept_code,
    .cfg_accept_mask, .bus_rx_pin, .bus_tx_pin);
  cmc_can_node u_node (.node_dominant, .bus_tx_pin, .bus_rx_pin);

  // --------------------------------------------
  // shared tasks
  // --------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [5:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // bounded wait on the run flag, then judge it
  task automatic wait_run(input logic e);
    for (int n = 0; n < 10 && engine_run !== e; n++) cyc(1);
    chk({7'h00, engine_run}, {7'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------------------------------
  // scenarios
  // --------------------------------------------
  task automatic t_reset;
    rd_reg(cmc_pkg::ADR_CTL0); chk(v, cmc_pkg::RST_CTL0);
    rd_reg(cmc_pkg::ADR_TFLG); chk(v, cmc_pkg::RST_TFLG);
    wr_reg(6'h3F, 8'hFF);
    rd_reg(6'h3F); chk(v, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_enable;
    wr_reg(cmc_pkg::ADR_CTL1, 8'h80);
    rd_reg(cmc_pkg::ADR_CTL1); chk(v, 8'h81);
    wr_reg(cmc_pkg::ADR_BTR0, 8'hA5); chk(cfg_timing_0, 8'hA5);
    wr_reg(cmc_pkg::ADR_IDAC, 8'h11); chk(cfg_accept_ctl, 8'h11);
    wr_reg(cmc_pkg::ADR_IDAR + 6'h1, 8'h22); chk(cfg_accept_code[15:8], 8'h22);
    wr_reg(cmc_pkg::ADR_IDMR + 6'h3, 8'h33); chk(cfg_accept_mask[31:24], 8'h33);
    sys_mode <= cmc_pkg::SYS_EMUL;
    wr_reg(cmc_pkg::ADR_CTL0, 8'h00); wait_run(1'b1);
    wr_reg(cmc_pkg::ADR_BTR0, 8'h5A); chk(cfg_timing_0, 8'hA5);
    wr_reg(cmc_pkg::ADR_IDMR + 6'h3, 8'h44); chk(cfg_accept_mask[31:24], 8'h33);
    wr_reg(cmc_pkg::ADR_CTL1, 8'h90);
    rd_reg(cmc_pkg::ADR_CTL1); chk(v, 8'h80);
    sys_mode <= cmc_pkg::SYS_SPECIAL;
    wr_reg(cmc_pkg::ADR_BTR1, 8'h3C); chk(cfg_timing_1, 8'h3C);
    sys_mode <= cmc_pkg::SYS_NORMAL;
    $display("test enable done");
  endtask
  // mid-frame init request: pin, abort pulse, register defaults
  task automatic t_abort;
    wr_reg(cmc_pkg::ADR_TFLG, 8'h01);
    mac_tx_request <= 1'b1; cyc(1); chk(mac_tx_grant, 1'b1);
    mac_tx_bit <= 1'b0; mac_busy <= 1'b1; cyc(2); chk(bus_tx_pin, 1'b0);
    wr_reg(cmc_pkg::ADR_TIER, 8'h05);
    wr_reg(cmc_pkg::ADR_TBSEL, 8'h02);
    wr_reg(cmc_pkg::ADR_CTL0, 8'h01);
    for (int n = 0; n < 4 && engine_abort !== 1'b1; n++) cyc(1);
    chk(engine_abort, 1'b1);
    chk(bus_tx_pin, 1'b1);
    mac_busy <= 1'b0;
    rd_reg(cmc_pkg::ADR_TIER); chk(v, 8'h00);
    rd_reg(cmc_pkg::ADR_TBSEL); chk(v, 8'h00);
    rd_reg(cmc_pkg::ADR_TFLG); chk(v, cmc_pkg::RST_TFLG);
    $display("test abort done");
  endtask
  task automatic t_listen;
    wr_reg(cmc_pkg::ADR_CTL1, 8'h90);
    wr_reg(cmc_pkg::ADR_CTL0, 8'h00); wait_run(1'b1);
    wr_reg(cmc_pkg::ADR_TFLG, 8'h01); chk(mac_tx_grant, 1'b0);
    cyc(4); chk(bus_tx_pin, 1'b1);
    chk(mac_rx_bit, 1'b0);
    mac_tx_bit <= 1'b1; node_dominant <= 1'b1;
    cyc(4); chk(mac_rx_bit, 1'b0);
    node_dominant <= 1'b0; mac_rx_frame_ok <= 1'b1; cyc(1);
    mac_rx_frame_ok <= 1'b0;
    rd_reg(cmc_pkg::ADR_RFLG); chk(v, 8'h01);
    wr_reg(cmc_pkg::ADR_CTL0, 8'h02);
    for (int n = 0; n < 8 && v !== 8'h92; n++) rd_reg(cmc_pkg::ADR_CTL1);
    chk(v, 8'h92);
    $display("test listen done");
  endtask

  // --------------------------------------------
  // clock, reset, sequence, watchdog
  // --------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    srst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 6'h00; wdata = 8'h00;
    sys_mode = cmc_pkg::SYS_NORMAL; mac_tx_bit = 1'b1; mac_busy = 1'b0;
    mac_tx_request = 1'b0; mac_rx_frame_ok = 1'b0; node_dominant = 1'b0;
    err_count = 0; checked = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_enable;
    t_abort;
    t_listen;
    summarize;
  end
  // the whole run needs well under a thousand cycles
  initial
  begin
    #100us;
    err_count++;
    summarize;
  end
endmodule
